// file: core/dbcds_top.v
// Clock source select, feedback model and two output banks
// Operation
// - Bank A select: ratios one, two, three, four
// - Bank B select: ratios two, four, five, eight
// - Feedback ratio 25 low, 32 high; default low
// - Bank divider selects default high when undriven
// - PLL select low bypasses to reference directly
// - Source select chooses crystal, default high crystal
// - Master reset high: outputs low, complements high
// - Master reset low runs; defaults low
// - Bank A enable low forces pair inactive
// - Bank B enable low forces both pairs inactive
// - Both output enables default high when undriven
// - One pair bank A, two from B divider
// - Banks have independent divider selects
// - Output equals reference times feedback over divider
// - Reference input defaults low, may float
//
// Implementation choices: the AXI4-Lite slave port and the address map.
module dbcds_top (
    input wire aclk, // System clock, 20 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire [3:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output wire s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output wire s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [3:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output wire s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire bank_a_ratio_sel_lo, // Bank A select, low bit
    input wire bank_a_ratio_sel_hi, // Bank A select, high bit
    input wire bank_b_ratio_sel_lo, // Bank B select, low bit
    input wire bank_b_ratio_sel_hi, // Bank B select, high bit
    input wire feedback_ratio_select, // Feedback ratio select
    input wire pll_use_select, // High uses the PLL, low bypasses
    input wire source_select, // High crystal, low reference input
    input wire master_divider_reset, // Divider reset, active high
    input wire bank_a_output_enable, // Bank A enable, active high
    input wire bank_b_output_enable, // Bank B enable, active high
    input wire reference_input, // Single ended reference clock
    input wire crystal_input, // Crystal oscillator input
    output reg crystal_output, // Crystal oscillator drive
    output wire bank_a_true_out, // Bank A true output
    output wire bank_a_comp_out, // Bank A complementary output
    output wire bank_b_true_out0, // Bank B pair 0 true
    output wire bank_b_comp_out0, // Bank B pair 0 complement
    output wire bank_b_true_out1, // Bank B pair 1 true
    output wire bank_b_comp_out1 // Bank B pair 1 complement
);

`include "dbcds_consts.vh"

// All pins in one vector, in control field order
wire [`DBCDS_NPIN-1:0] pin_raw = {crystal_input, reference_input,
    bank_b_output_enable, bank_a_output_enable, master_divider_reset,
    source_select, pll_use_select, feedback_ratio_select,
    bank_b_ratio_sel_hi, bank_b_ratio_sel_lo,
    bank_a_ratio_sel_hi, bank_a_ratio_sel_lo};
wire [`DBCDS_NPIN-1:0] pin_rst = `DBCDS_PIN_RST; // Pull levels
wire [`DBCDS_NPIN-1:0] pin_sync; // Synchronised pin levels

// Two flop synchroniser per pin; each starts at its pad pull level,
// so a pin nobody drives reads as its documented default
genvar gi;
generate
    for (gi = 0; gi < `DBCDS_NPIN; gi = gi + 1)
    begin : g_sync
        reg s1_ff; // First stage, read only by second stage
        reg s2_ff; // Second stage, safe to use
        always @(posedge aclk)
        begin
            if (!aresetn)
            begin
                s1_ff <= pin_rst[gi];
                s2_ff <= pin_rst[gi];
            end
            else
            begin
                s1_ff <= pin_raw[gi];
                s2_ff <= s1_ff;
            end
        end
        assign pin_sync[gi] = s2_ff;
    end
endgenerate

// Software control: settings image plus override bit
reg [10:0] ctrl_ff;
// Effective settings: pins unless software overrides them
wire ovr = ctrl_ff[`DBCDS_B_OVR];
wire [`DBCDS_NSET-1:0] eff = ovr ? ctrl_ff[`DBCDS_NSET-1:0]
                                 : pin_sync[`DBCDS_NSET-1:0];

// Bank A ratio decode
function [3:0] a_ratio;
    input [1:0] sel;
    begin
        case (sel)
            2'b00: a_ratio = `DBCDS_A_DIV_00;
            2'b01: a_ratio = `DBCDS_A_DIV_01;
            2'b10: a_ratio = `DBCDS_A_DIV_10;
            default: a_ratio = `DBCDS_A_DIV_11;
        endcase
    end
endfunction

// Bank B ratio decode
function [3:0] b_ratio;
    input [1:0] sel;
    begin
        case (sel)
            2'b00: b_ratio = `DBCDS_B_DIV_00;
            2'b01: b_ratio = `DBCDS_B_DIV_01;
            2'b10: b_ratio = `DBCDS_B_DIV_10;
            default: b_ratio = `DBCDS_B_DIV_11;
        endcase
    end
endfunction

// Each bank has its own select pair
wire [3:0] ratio_a = a_ratio({eff[`DBCDS_B_ASEL_HI],
                              eff[`DBCDS_B_ASEL_LO]});
wire [3:0] ratio_b = b_ratio({eff[`DBCDS_B_BSEL_HI],
                              eff[`DBCDS_B_BSEL_LO]});

// Selected reference level and its edges
wire src_xtal = eff[`DBCDS_B_SRC];
wire ref_lvl = src_xtal ? pin_sync[`DBCDS_B_XTAL]
                        : pin_sync[`DBCDS_B_REF];
reg ref_d_ff; // Previous reference level
wire ref_rise = ref_lvl && !ref_d_ff;
wire ref_fall = !ref_lvl && ref_d_ff;

// Reference delay and crystal drive; drive is parked low when the
// crystal is not the source, to save switching power
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        ref_d_ff <= 1'b0;
        crystal_output <= 1'b0;
    end
    else
    begin
        ref_d_ff <= ref_lvl;
        crystal_output <= src_xtal & ~pin_sync[`DBCDS_B_XTAL];
    end
end

// Reference period measurement in system clock cycles
reg [`DBCDS_PER_W-1:0] per_cnt_ff; // Cycles since last rise
reg [`DBCDS_PER_W-1:0] period_ff; // Last full period
reg seen_ff; // One rise seen
reg lock_ff; // A full period has been measured
wire per_sat = (per_cnt_ff == `DBCDS_PER_MAX);

// Period counter; a stopped reference saturates it and drops lock
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        per_cnt_ff <= {`DBCDS_PER_W{1'b0}};
        period_ff <= {`DBCDS_PER_W{1'b0}};
        seen_ff <= 1'b0;
        lock_ff <= 1'b0;
    end
    else if (ref_rise)
    begin
        per_cnt_ff <= {{(`DBCDS_PER_W-1){1'b0}}, 1'b1};
        period_ff <= per_cnt_ff;
        seen_ff <= 1'b1;
        lock_ff <= seen_ff;
    end
    else if (per_sat)
    begin
        seen_ff <= 1'b0;
        lock_ff <= 1'b0;
    end
    else
    begin
        per_cnt_ff <= per_cnt_ff + {{(`DBCDS_PER_W-1){1'b0}}, 1'b1};
    end
end

// Feedback model: two ticks per source period, ratio periods per
// reference period, spread by an accumulator. At most one tick per
// cycle, so the reference must be slow against the system clock.
wire [5:0] fb_ratio = eff[`DBCDS_B_FB] ? `DBCDS_FB_HI
                                       : `DBCDS_FB_LO;
wire [6:0] fb_step = {fb_ratio, 1'b0};
reg [16:0] acc_ff; // Phase accumulator
wire [16:0] acc_sum = acc_ff + {10'h000, fb_step};
wire [16:0] per_ext = {1'b0, period_ff};
wire pll_tick = lock_ff && (acc_sum >= per_ext);
wire pll_on = eff[`DBCDS_B_PLL];

// Accumulator, cleared while bypassed or unlocked
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        acc_ff <= 17'h0_0000;
    end
    else if (!pll_on || !lock_ff)
    begin
        acc_ff <= 17'h0_0000;
    end
    else if (pll_tick)
    begin
        acc_ff <= acc_sum - per_ext;
    end
    else
    begin
        acc_ff <= acc_sum;
    end
end

// Divider timebase: PLL ticks, or each reference edge when bypassed
wire div_tick = pll_on ? pll_tick : (ref_rise | ref_fall);
wire div_hold = eff[`DBCDS_B_MR];

// Bank A divider
dbcds_bank_div u_bank_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(div_hold),
    .tick(div_tick),
    .ratio(ratio_a),
    .oe(eff[`DBCDS_B_OEA]),
    .out_true_ff(bank_a_true_out),
    .out_comp_ff(bank_a_comp_out)
);

// Bank B divider, shared by both pairs
wire b_true;
wire b_comp;
dbcds_bank_div u_bank_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(div_hold),
    .tick(div_tick),
    .ratio(ratio_b),
    .oe(eff[`DBCDS_B_OEB]),
    .out_true_ff(b_true),
    .out_comp_ff(b_comp)
);
assign bank_b_true_out0 = b_true;
assign bank_b_comp_out0 = b_comp;
assign bank_b_true_out1 = b_true;
assign bank_b_comp_out1 = b_comp;

// Write channel state
reg aw_got_ff; // Address held
reg [3:0] awaddr_ff;
reg w_got_ff; // Data held
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
wire do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;
wire wr_ctrl = (awaddr_ff[3:2] == `DBCDS_CTRL_OFS >> 2);
// Byte lane mask over the 11 control bits
wire [10:0] wmask = {{3{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

// Write path: address and data taken in either order, one write
// in flight; only the control word is writable
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_got_ff <= 1'b0;
        awaddr_ff <= 4'h0;
        w_got_ff <= 1'b0;
        wdata_ff <= 32'h0000_0000;
        wstrb_ff <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `DBCDS_RESP_OKAY;
        ctrl_ff <= `DBCDS_CTRL_RST;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_ctrl)
            begin
                ctrl_ff <= (ctrl_ff & ~wmask) | (wdata_ff[10:0] & wmask);
                s_axi_bresp <= `DBCDS_RESP_OKAY;
            end
            else
            begin
                // Read only or unmapped word
                s_axi_bresp <= `DBCDS_RESP_SLVERR;
            end
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// Read decode
assign s_axi_arready = !s_axi_rvalid;
wire [31:0] stat_word = {20'h0_0000, lock_ff, ovr, eff};
wire [31:0] per_word = {16'h0000, period_ff};

// Read path: data registered on the address handshake
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `DBCDS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DBCDS_RESP_OKAY;
        case (s_axi_araddr[3:2])
            `DBCDS_CTRL_OFS >> 2: s_axi_rdata <= {21'h00_0000, ctrl_ff};
            `DBCDS_STAT_OFS >> 2: s_axi_rdata <= stat_word;
            `DBCDS_PER_OFS >> 2: s_axi_rdata <= per_word;
            default:
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `DBCDS_RESP_SLVERR;
            end
        endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule

// file: core/dbcds_consts.vh
// Constants for the dual bank clock divider select block
`ifndef DBCDS_CONSTS_VH
`define DBCDS_CONSTS_VH

// Register bus address width and byte offsets
`define DBCDS_AW 4
`define DBCDS_CTRL_OFS 4'h0
`define DBCDS_STAT_OFS 4'h4
`define DBCDS_PER_OFS 4'h8

// AXI response codes
`define DBCDS_RESP_OKAY 2'h0
`define DBCDS_RESP_SLVERR 2'h2

// Pin vector positions, also the control and status field layout
`define DBCDS_NPIN 12
`define DBCDS_NSET 10
`define DBCDS_B_ASEL_LO 0
`define DBCDS_B_ASEL_HI 1
`define DBCDS_B_BSEL_LO 2
`define DBCDS_B_BSEL_HI 3
`define DBCDS_B_FB 4
`define DBCDS_B_PLL 5
`define DBCDS_B_SRC 6
`define DBCDS_B_MR 7
`define DBCDS_B_OEA 8
`define DBCDS_B_OEB 9
`define DBCDS_B_REF 10
`define DBCDS_B_XTAL 11
`define DBCDS_B_OVR 10
`define DBCDS_B_LOCK 11

// Undriven pin levels, the pull of each pad
`define DBCDS_PIN_RST 12'h36F
`define DBCDS_CTRL_RST 11'h36F

// Bank A output ratios per select code
`define DBCDS_A_DIV_00 4'h1
`define DBCDS_A_DIV_01 4'h2
`define DBCDS_A_DIV_10 4'h3
`define DBCDS_A_DIV_11 4'h4

// Bank B output ratios per select code
`define DBCDS_B_DIV_00 4'h2
`define DBCDS_B_DIV_01 4'h4
`define DBCDS_B_DIV_10 4'h5
`define DBCDS_B_DIV_11 4'h8

// Feedback ratios and divider reset ratio
`define DBCDS_FB_LO 6'h19
`define DBCDS_FB_HI 6'h20
`define DBCDS_RATIO_RST 4'h1

// Reference period counter
`define DBCDS_PER_W 16
`define DBCDS_PER_MAX 16'hFFFF

`endif

// file: core/dbcds_bank_div.v
// One output bank divider with glitch free enable and complement
module dbcds_bank_div (
    input wire aclk, // System clock
    input wire aresetn, // Synchronous reset, active low
    input wire hold, // Master divider reset, active high
    input wire tick, // One pulse per half period of the source clock
    input wire [3:0] ratio, // Requested divide ratio, 1 to 8
    input wire oe, // Bank output enable
    output reg out_true_ff, // True output
    output reg out_comp_ff // Complementary output
);

`include "dbcds_consts.vh"

reg [3:0] cnt_ff; // Source half periods within one output period
reg [3:0] nxt_cnt;
reg [3:0] ratio_ff; // Ratio in use for the current period
reg [3:0] nxt_ratio;
reg gate_ff; // Enable in use for the current period
reg nxt_gate;
reg nxt_true;

// Last half period index of an output period
wire [4:0] last_cnt = {ratio_ff, 1'b0} - 5'h01;
wire at_end = ({1'b0, cnt_ff} == last_cnt);

// Next state; ratio and enable change only at a period boundary or in hold,
// where the output is low, so no runt pulse can appear
always @*
begin
    nxt_cnt = cnt_ff;
    nxt_ratio = ratio_ff;
    nxt_gate = gate_ff;
    if (hold)
    begin
        // Held dividers restart cleanly from the period start
        nxt_cnt = 4'h0;
        nxt_ratio = ratio;
        nxt_gate = oe;
    end
    else if (tick)
    begin
        if (at_end)
        begin
            nxt_cnt = 4'h0;
            nxt_ratio = ratio;
            nxt_gate = oe;
        end
        else
        begin
            nxt_cnt = cnt_ff + 4'h1;
        end
    end
    // High for the first ratio half periods of each period
    nxt_true = !hold && nxt_gate && (nxt_cnt < nxt_ratio);
end

// State and output registers
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        cnt_ff <= 4'h0;
        ratio_ff <= `DBCDS_RATIO_RST;
        gate_ff <= 1'b0;
        out_true_ff <= 1'b0;
        out_comp_ff <= 1'b1;
    end
    else
    begin
        cnt_ff <= nxt_cnt;
        ratio_ff <= nxt_ratio;
        gate_ff <= nxt_gate;
        out_true_ff <= nxt_true;
        out_comp_ff <= ~nxt_true;
    end
end

endmodule

// file: verif/dbcds_clk_model.sv
// Far side model: reference and crystal sources, output edge counter
module dbcds_clk_model (
    input wire logic aclk, // System clock
    input wire logic [7:0] ref_half, // Reference half period, 0 stops
    input wire logic [7:0] xtal_half, // Crystal half period
    input wire logic clr, // Clears both edge counts
    input wire logic bank_a_true_out, // Bank A true output
    input wire logic bank_b_true_out0, // Bank B pair 0 true output
    output logic reference_input, // Reference clock
    output logic crystal_input, // Crystal clock
    output logic [15:0] cnt_a, // Rises seen on bank A
    output logic [15:0] cnt_b // Rises seen on bank B
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rc = 8'h00; // Reference phase count
    logic [7:0] xc = 8'h00; // Crystal phase count
    logic qa_d = 1'b0; // Bank A output one cycle ago
    logic qb_d = 1'b0; // Bank B output one cycle ago
    initial
    begin
        reference_input = 1'b0;
        crystal_input = 1'b0;
        cnt_a = 16'h0000;
        cnt_b = 16'h0000;
    end
    // A stopped reference rests low, as its pull-down would leave it
    always @(posedge aclk)
    begin
        if (ref_half == 8'h00)
        begin
            rc <= 8'h00;
            reference_input <= 1'b0;
        end
        else if (rc >= ref_half - 8'h01)
        begin
            rc <= 8'h00;
            reference_input <= !reference_input;
        end
        else
            rc <= rc + 8'h01;
        // The crystal runs free, as a real oscillator does
        if (xc >= xtal_half - 8'h01)
        begin
            xc <= 8'h00;
            crystal_input <= !crystal_input;
        end
        else
            xc <= xc + 8'h01;
        qa_d <= bank_a_true_out;
        qb_d <= bank_b_true_out0;
        cnt_a <= clr ? 16'h0000 : cnt_a + {15'h0000, bank_a_true_out & ~qa_d};
        cnt_b <= clr ? 16'h0000 : cnt_b + {15'h0000, bank_b_true_out0 & ~qb_d};
    end
endmodule

// file: verif/dbcds_checker.sv
// Port level assertions for the dual bank divider top
module dbcds_checker (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wready, // Write data ready
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready, // Read ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic master_divider_reset, // Divider reset
    input wire logic bank_a_output_enable, // Bank A enable
    input wire logic bank_b_output_enable, // Bank B enable
    input wire logic bank_a_true_out, // Bank A true
    input wire logic bank_a_comp_out, // Bank A complement
    input wire logic bank_b_true_out0, // Bank B pair 0 true
    input wire logic bank_b_comp_out0, // Bank B pair 0 complement
    input wire logic bank_b_true_out1, // Bank B pair 1 true
    input wire logic bank_b_comp_out1 // Bank B pair 1 complement
);
    timeunit 1ns;
    timeprecision 1ns;
    // Covers several slow bank periods, since disable waits for a boundary
    localparam int OE_LIM = 300;
    logic [9:0] oea_lo_ff; // Cycles bank A enable held low
    logic [9:0] oeb_lo_ff; // Cycles bank B enable held low
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Saturating counts of disabled cycles
    always_ff @(posedge aclk)
    begin
        if (!aresetn || bank_a_output_enable)
            oea_lo_ff <= 10'h000;
        else if (oea_lo_ff < OE_LIM)
            oea_lo_ff <= oea_lo_ff + 10'h001;
        if (!aresetn || bank_b_output_enable)
            oeb_lo_ff <= 10'h000;
        else if (oeb_lo_ff < OE_LIM)
            oeb_lo_ff <= oeb_lo_ff + 10'h001;
    end
    // Pin crosses two sync flops, then the divider clears
    sequence s_mr_held;
        master_divider_reset [*5];
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_comp_a_inv: assert property (
        bank_a_comp_out == !bank_a_true_out)
        else $error("bank A complement not inverse");
    a_comp_b_inv: assert property (
        bank_b_comp_out0 == !bank_b_true_out0
        && bank_b_comp_out1 == !bank_b_true_out1)
        else $error("bank B complement not inverse");
    a_b_pairs_same: assert property (
        bank_b_true_out1 == bank_b_true_out0)
        else $error("bank B pairs differ");
    a_mr_forces_low: assert property (s_mr_held |-> !bank_a_true_out
        && !bank_b_true_out0) else $error("outputs run in divider reset");
    a_oea_quiet: assert property (
        oea_lo_ff == OE_LIM |-> !bank_a_true_out)
        else $error("bank A runs while disabled");
    a_oeb_quiet: assert property (
        oeb_lo_ff == OE_LIM |-> !bank_b_true_out0)
        else $error("bank B runs while disabled");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_b_blocks: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule

bind dbcds_top dbcds_checker u_chk (.*);

// file: verif/tb_dual_bank_clock_divider_select.sv
// Self-checking bench for the dual bank clock divider top
`include "dbcds_consts.vh"
module tb_dual_bank_clock_divider_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, clr;
    logic s_axi_arvalid, s_axi_rready, source_select, master_divider_reset;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, rd;
    logic bank_a_ratio_sel_lo, bank_a_ratio_sel_hi, bank_b_ratio_sel_lo;
    logic bank_b_ratio_sel_hi, feedback_ratio_select, pll_use_select;
    logic bank_a_output_enable, bank_b_output_enable;
    logic [7:0] ref_half, xtal_half;
    logic [1:0] rs;
    logic [15:0] ca, cb;
    logic [5:0] o;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, reference_input, crystal_input, crystal_output;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire bank_a_true_out, bank_a_comp_out, bank_b_true_out0;
    wire bank_b_comp_out0, bank_b_true_out1, bank_b_comp_out1;
    wire [15:0] cnt_a, cnt_b;
    int num_errors = 0;
    int check_count = 0;
    int ra[4] = '{1, 2, 3, 4}; // Bank A ratio per select code
    int rb[4] = '{2, 4, 5, 8}; // Bank B ratio per select code

    dbcds_top DUT (.*);
    dbcds_clk_model u_far (.*);

    always #25 aclk = ~aclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Counts are phase dependent, so allow two edges either way
    task automatic near(input logic [15:0] seen, input int exp);
        check((seen + 2 >= exp && seen <= exp + 2) ? exp : seen, exp);
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic ka, kw, kb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ka = s_axi_awvalid && s_axi_awready;
            kw = s_axi_wvalid && s_axi_wready;
            kb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ka) s_axi_awvalid <= 1'b0;
            if (kw) s_axi_wvalid <= 1'b0;
        end while (!kb);
        s_axi_bready <= 1'b0;
        // One idle edge, so a following call never re-drives in this step
        @(posedge aclk);
    endtask

    // Ready is offered with the address and held until the answer
    task automatic axr(input logic [3:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ka, kr;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ka = s_axi_arvalid && s_axi_arready;
            kr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ka) s_axi_arvalid <= 1'b0;
        end while (!kr);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic meas(input int w, input int settle);
        repeat (settle) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (w) @(posedge aclk);
        @(negedge aclk);
        ca = cnt_a;
        cb = cnt_b;
        o = {bank_a_true_out, bank_a_comp_out, bank_b_true_out0,
            bank_b_comp_out0, bank_b_true_out1, bank_b_comp_out1};
        @(posedge aclk);
    endtask

    task automatic set_sel(input logic [1:0] a, input logic [1:0] b);
        {bank_a_ratio_sel_hi, bank_a_ratio_sel_lo} <= a;
        {bank_b_ratio_sel_hi, bank_b_ratio_sel_lo} <= b;
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog, well above the expected run length
    initial
    begin
        repeat (30000) @(posedge aclk);
        num_errors++;
        end_of_test();
    end

    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, clr} = 4'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00F;
        s_axi_wdata = 32'h0000_0000;
        // Pins start at their pulled levels
        {bank_a_ratio_sel_hi, bank_a_ratio_sel_lo} = 2'h3;
        {bank_b_ratio_sel_hi, bank_b_ratio_sel_lo} = 2'h3;
        {feedback_ratio_select, pll_use_select, source_select} = 3'h3;
        master_divider_reset = 1'b0;
        {bank_a_output_enable, bank_b_output_enable} = 2'h3;
        ref_half = 8'h04;
        xtal_half = 8'h06;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Register reset values, read-only and unmapped places
        axr(`DBCDS_CTRL_OFS, rd, rs);
        check(rd, 32'h0000_036F);
        axr(`DBCDS_STAT_OFS, rd, rs);
        check(rd & 32'h0000_07FF, 32'h0000_036F);
        axw(`DBCDS_STAT_OFS, 32'h0000_0000, rs);
        check(rs, `DBCDS_RESP_SLVERR);
        axr(4'hC, rd, rs);
        check(rd, 32'h0000_0000);
        check(rs, `DBCDS_RESP_SLVERR);
        axw(`DBCDS_CTRL_OFS, 32'h0000_036F, rs);
        check(rs, `DBCDS_RESP_OKAY);
        // Bypass, every select code, banks set apart
        pll_use_select <= 1'b0;
        source_select <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            set_sel(i[1:0], 2'(3 - i));
            meas(960, 200);
            near(ca, 120 / ra[i]);
            near(cb, 120 / rb[3 - i]);
        end
        // A stopped reference rests low, so the dividers stand still
        ref_half <= 8'h00;
        meas(400, 40);
        check(ca, 16'h0000);
        check(crystal_output, 1'b0);
        // Crystal source, slower period
        source_select <= 1'b1;
        set_sel(2'h0, 2'h3);
        meas(960, 200);
        near(ca, 80);
        // Each bank disabled alone
        bank_a_output_enable <= 1'b0;
        meas(400, 200);
        check({ca, o[5:4]}, {16'h0000, 2'h1});
        check(cb != 0, 1);
        bank_a_output_enable <= 1'b1;
        bank_b_output_enable <= 1'b0;
        meas(400, 200);
        check({cb, o[3:0]}, {16'h0000, 4'h5});
        check(ca != 0, 1);
        // Divider reset, then release
        bank_b_output_enable <= 1'b1;
        master_divider_reset <= 1'b1;
        meas(200, 20);
        check({ca, o}, {16'h0000, 6'h15});
        master_divider_reset <= 1'b0;
        meas(960, 20);
        near(ca, 80);
        near(cb, 10);
        // PLL with both feedback ratios
        pll_use_select <= 1'b1;
        source_select <= 1'b0;
        ref_half <= 8'h32;
        meas(800, 600);
        near(ca, 200);
        near(cb, 25);
        feedback_ratio_select <= 1'b1;
        meas(800, 600);
        near(ca, 256);
        near(cb, 32);
        end_of_test();
    end
endmodule
